// ===== hw/adc_conversion_control.sv
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// What this block does
// - justify bit sets right or left result
// - ref select bit picks pin or supply
// - channel field routes inputs, DAC, fixed reference
// - writing start begins conversion, reads busy
// - hardware clears start when conversion ends
// - enable bit powers converter, off draws nothing
// - clock field picks divisor or RC/16
// - left justified layout of result registers
// - right justified layout of result registers
// - result registers are read-only
// - completion clears start, flags, loads result
// - conversion lasts eleven bit periods
// - clearing start aborts, result kept
// - abort waits two bit periods, then acquires
module adc_conversion_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rc_osc_tick,
  input wire logic comparator_in,
  output adc_ctrl_pkg::analog_ctrl_t analog_ctrl,
  output logic conv_done_flag
);
  import adc_ctrl_pkg::*;

  // ==========================================================
  // control registers
  logic [7:0] ctrl0_ff;
  logic [2:0] clksel_ff;
  logic [9:0] result_ff;
  logic [9:0] sar_ff;
  logic done_ff;
  conv_state_t state_ff;
  logic [3:0] bitcnt_ff;
  logic [5:0] div_ff;
  logic [3:0] rcdiv_ff;
  logic [1:0] rc_sync_ff;
  logic [1:0] cmp_sync_ff;
  logic rc_prev_ff;
  logic tick;

  // ==========================================================
  // AXI4-Lite write path: address and data taken in either order
  logic aw_held_ff;
  logic w_held_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_fire;
  logic wr_map;

  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
  assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_map = (awaddr_ff == CTRL0_OFFSET) || (awaddr_ff == CTRL1_OFFSET);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= {s_axi_awaddr[3:2], 2'b00};
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      // result registers answer okay but ignore the data
      s_axi_bresp <= (wr_map || awaddr_ff == RES_HIGH_OFFSET || awaddr_ff == RES_LOW_OFFSET)
                     ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic ctrl0_wr;
  logic ctrl1_wr;
  assign ctrl0_wr = wr_fire && awaddr_ff == CTRL0_OFFSET && wstrb_ff[0];
  assign ctrl1_wr = wr_fire && awaddr_ff == CTRL1_OFFSET && wstrb_ff[0];

  // ==========================================================
  // conversion engine
  logic finish;
  logic abort;
  logic start_req;
  assign finish = state_ff == ST_CONVERT && tick && bitcnt_ff == 4'(CONV_BIT_PERIODS - 1);
  // clearing start (or power) mid-conversion aborts it
  assign abort = state_ff == ST_CONVERT && ctrl0_wr
                 && (!wdata_ff[START_BIT] || !wdata_ff[ENABLE_BIT]);
  assign start_req = ctrl0_wr && wdata_ff[START_BIT] && wdata_ff[ENABLE_BIT]
                     && state_ff == ST_IDLE;

  logic nxt_start;
  always_comb begin
    nxt_start = ctrl0_ff[START_BIT];
    if (ctrl0_wr) begin
      nxt_start = wdata_ff[START_BIT] && wdata_ff[ENABLE_BIT] && state_ff != ST_HOLDOFF;
    end
    // completion wins over a simultaneous software write
    if (finish && !abort) begin
      nxt_start = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_ff <= CTRL0_RESET;
    end else begin
      if (ctrl0_wr) begin
        ctrl0_ff[7:2] <= wdata_ff[7:2];
        ctrl0_ff[ENABLE_BIT] <= wdata_ff[ENABLE_BIT];
      end
      ctrl0_ff[START_BIT] <= nxt_start;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clksel_ff <= CLKSEL_RESET;
    end else if (ctrl1_wr) begin
      clksel_ff <= wdata_ff[CLKSEL_LSB +: 3];
    end
  end

  // ==========================================================
  // bit-period clock: system divisor or RC oscillator / 16
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_sync_ff <= 2'b00;
      cmp_sync_ff <= 2'b00;
      rc_prev_ff <= 1'b0;
    end else begin
      rc_sync_ff <= {rc_sync_ff[0], rc_osc_tick};
      cmp_sync_ff <= {cmp_sync_ff[0], comparator_in};
      rc_prev_ff <= rc_sync_ff[1];
    end
  end

  logic [5:0] div_last;
  always_comb begin
    case (clksel_ff)
      3'b000: div_last = 6'd1;
      3'b001: div_last = 6'd7;
      3'b010: div_last = 6'd31;
      3'b100: div_last = 6'd3;
      3'b101: div_last = 6'd15;
      3'b110: div_last = 6'd63;
      default: div_last = 6'd0;
    endcase
  end

  logic rc_mode;
  logic rc_edge;
  assign rc_mode = clksel_ff[1:0] == 2'b11;
  assign rc_edge = rc_sync_ff[1] && !rc_prev_ff;
  assign tick = rc_mode ? (rc_edge && rcdiv_ff == 4'(RC_DIVISOR - 1))
                        : (div_ff == div_last);

  // dividers idle while powered down so the converter draws nothing
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl0_ff[ENABLE_BIT] || state_ff == ST_IDLE) begin
      div_ff <= 6'd0;
      rcdiv_ff <= 4'h0;
    end else begin
      div_ff <= (div_ff >= div_last) ? 6'd0 : div_ff + 6'd1;
      if (rc_edge) begin
        rcdiv_ff <= rcdiv_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
      bitcnt_ff <= 4'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          bitcnt_ff <= 4'h0;
          if (start_req) begin
            state_ff <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (abort) begin
            state_ff <= ST_HOLDOFF;
            bitcnt_ff <= 4'h0;
          end else if (finish) begin
            state_ff <= ST_IDLE;
            bitcnt_ff <= 4'h0;
          end else if (tick) begin
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end
        end
        ST_HOLDOFF: begin
          if (tick && bitcnt_ff == 4'(ABORT_BIT_PERIODS - 1)) begin
            state_ff <= ST_IDLE; // acquisition resumes
            bitcnt_ff <= 4'h0;
          end else if (tick) begin
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // successive approximation: bit periods 1..10 resolve msb first
  always_ff @(posedge aclk) begin
    if (!aresetn || state_ff == ST_IDLE) begin
      sar_ff <= RESULT_RESET;
    end else if (state_ff == ST_CONVERT && tick && bitcnt_ff != 4'h0) begin
      sar_ff[4'(CONV_BIT_PERIODS - 1) - bitcnt_ff] <= cmp_sync_ff[1];
    end
  end

  // single 10-bit store so both result halves change together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_ff <= RESULT_RESET;
    end else if (finish && !abort) begin
      // the lsb is resolved on this same tick, so take it straight from the comparator
      result_ff <= {sar_ff[9:1], cmp_sync_ff[1]};
    end
  end

  // sticky done flag; set wins over the software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_ff <= 1'b0;
    end else if (finish && !abort) begin
      done_ff <= 1'b1;
    end else if (ctrl1_wr && wdata_ff[0]) begin
      done_ff <= 1'b0;
    end
  end
  assign conv_done_flag = done_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl.powered <= ctrl0_ff[ENABLE_BIT];
      analog_ctrl.ext_ref <= ctrl0_ff[REF_SEL_BIT];
      analog_ctrl.channel <= ctrl0_ff[CHAN_LSB +: 4];
      analog_ctrl.sample <= ctrl0_ff[ENABLE_BIT] && state_ff == ST_IDLE;
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  logic [7:0] res_high;
  logic [7:0] res_low;
  always_comb begin
    if (ctrl0_ff[JUSTIFY_BIT]) begin
      res_high = {6'h00, result_ff[9:8]};
      res_low = result_ff[7:0];
    end else begin
      res_high = result_ff[9:2];
      res_low = {result_ff[1:0], 6'h00};
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'b00})
        CTRL0_OFFSET: s_axi_rdata <= {24'h000000, ctrl0_ff};
        CTRL1_OFFSET: s_axi_rdata <= {24'h000000, 1'b0, clksel_ff, 3'h0, done_ff};
        RES_HIGH_OFFSET: s_axi_rdata <= {24'h000000, res_high};
        RES_LOW_OFFSET: s_axi_rdata <= {24'h000000, res_low};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  sequence conv_done_s;
    finish && !abort;
  endsequence

  busy_reads_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == ST_CONVERT |-> ctrl0_ff[START_BIT])
    else $error("start bit low during conversion");
  done_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done_s |=> !ctrl0_ff[START_BIT] && done_ff)
    else $error("completion did not clear start");
  result_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done_s |=> result_ff == {$past(sar_ff[9:1]), $past(cmp_sync_ff[1])})
    else $error("result not loaded at completion");
  abort_keeps_a: assert property (@(posedge aclk) disable iff (!aresetn)
    abort |=> result_ff == $past(result_ff) && state_ff == ST_HOLDOFF)
    else $error("abort changed result");
  result_stable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(finish) |-> $stable(result_ff))
    else $error("result changed without completion");
  left_layout_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && !ctrl0_ff[JUSTIFY_BIT] && s_axi_araddr[3:2] == 2'h3
    |=> s_axi_rdata == {24'h000000, $past(result_ff[1:0]), 6'h00})
    else $error("left layout wrong");
  right_layout_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && ctrl0_ff[JUSTIFY_BIT] && s_axi_araddr[3:2] == 2'h2
    |=> s_axi_rdata == {30'h00000000, $past(result_ff[9:8])})
    else $error("right layout wrong");
  eleven_periods_a: assert property (@(posedge aclk) disable iff (!aresetn)
    finish |-> bitcnt_ff == 4'hA && state_ff == ST_CONVERT)
    else $error("conversion length wrong");
  off_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl0_ff[ENABLE_BIT] && !$past(ctrl0_ff[ENABLE_BIT]) |-> div_ff == 6'h00 && rcdiv_ff == 4'h0)
    else $error("divider runs while off");
endmodule : adc_conversion_control

// ===== hw/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  // ==========================================================
  // register map (byte addresses; each register one aligned word)
  localparam logic [3:0] CTRL0_OFFSET = 4'h0;
  localparam logic [3:0] CTRL1_OFFSET = 4'h4;
  localparam logic [3:0] RES_HIGH_OFFSET = 4'h8;
  localparam logic [3:0] RES_LOW_OFFSET = 4'hC;
  // ==========================================================
  // control field positions
  localparam int JUSTIFY_BIT = 7;
  localparam int REF_SEL_BIT = 6;
  localparam int CHAN_LSB = 2;
  localparam int START_BIT = 1;
  localparam int ENABLE_BIT = 0;
  localparam int CLKSEL_LSB = 4;
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [2:0] CLKSEL_RESET = 3'h0;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  // ==========================================================
  // channel codes
  localparam logic [3:0] CHAN_DAC = 4'hE;
  localparam logic [3:0] CHAN_FIXED_REF = 4'hF;
  // ==========================================================
  // timing
  localparam int CONV_BIT_PERIODS = 11;
  localparam int ABORT_BIT_PERIODS = 2;
  localparam int RC_DIVISOR = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_HOLDOFF = 2'b10
  } conv_state_t;

  // analog front-end steering
  typedef struct packed {
    logic powered;
    logic ext_ref;
    logic [3:0] channel;
    logic sample;
  } analog_ctrl_t;
endpackage : adc_ctrl_pkg

// ===== tb/adc_analog_model.sv
`timescale 1ns/100ps
// =====
// analog far side: comparator and rc oscillator
module adc_analog_model
  import adc_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire adc_ctrl_pkg::analog_ctrl_t analog_ctrl,
  output logic comparator_in,
  output logic rc_osc_tick
);
  // free running, phase unrelated to aclk
  initial begin
    rc_osc_tick = 1'b0;
    forever #15 rc_osc_tick = ~rc_osc_tick;
  end
  // even channels sit above every trial level, odd ones below;
  // while off or sampling the comparator output is meaningless
  assign comparator_in = (analog_ctrl.powered && !analog_ctrl.sample) ?
                         ~analog_ctrl.channel[0] : rc_osc_tick;
endmodule : adc_analog_model

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import adc_ctrl_pkg::*;
  typedef struct {logic [7:0] c0; logic [2:0] cs; int dv; logic [7:0] hi; logic [7:0] lo;} row_t;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, cmp, rc, done;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  analog_ctrl_t actl;
  int err_total, checks_done, n;
  logic [7:0] rd;
  row_t rows [7];
  // =====
  // design and far side
  adc_conversion_control uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rc_osc_tick(rc), .comparator_in(cmp),
    .analog_ctrl(actl), .conv_done_flag(done));
  adc_analog_model far (.aclk(aclk), .analog_ctrl(actl), .comparator_in(cmp),
    .rc_osc_tick(rc));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // =====
  // checks and bus tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // readies are combinational on registered state, so the negedge value
  // is the value seen at the following rising edge
  task automatic axi_write(input logic [3:0] a, input logic [7:0] d);
    logic ta, tw, got;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      got = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!got);
    bready <= 1'b0;
    chk("bresp", RESP_OKAY, r);
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, output logic [7:0] d);
    logic t, got;
    logic [31:0] v;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      t = arvalid && arready;
      got = rvalid;
      v = rdata;
      r = rresp;
      @(posedge aclk);
      if (t) arvalid <= 1'b0;
    end while (!got);
    rready <= 1'b0;
    chk("rresp", RESP_OKAY, r);
    chk("rdata_upper", 32'h0, {8'h00, v[31:8]});
    d = v[7:0];
  endtask : axi_read
  task automatic run(input logic [7:0] c, output int k);
    axi_write(CTRL0_OFFSET, c | 8'h02);
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(negedge aclk);
      k++;
    end
  endtask : run
  task automatic read_all_zero();
    for (int i = 0; i < 4; i++) begin
      axi_read(4'(i * 4), rd);
      chk("reset_value", 32'h0, rd);
    end
  endtask : read_all_zero
  // =====
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'h1;
    err_total = 0;
    checks_done = 0;
    rows = '{'{8'h81, 3'h0, 2, 8'h03, 8'hFF}, '{8'h41, 3'h1, 8, 8'hFF, 8'hC0},
             '{8'h85, 3'h2, 32, 8'h00, 8'h00}, '{8'h49, 3'h4, 4, 8'hFF, 8'hC0},
             '{8'h8D, 3'h5, 16, 8'h00, 8'h00}, '{8'h39, 3'h6, 64, 8'hFF, 8'hC0},
             '{8'hBD, 3'h3, 60, 8'h00, 8'h00}};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    read_all_zero();
    axi_write(CTRL1_OFFSET, 8'hFE);
    axi_read(CTRL1_OFFSET, rd);
    chk("ctrl1_unused", 32'h70, rd);
    for (int i = 0; i < 7; i++) begin
      axi_write(CTRL1_OFFSET, {1'b0, rows[i].cs, 4'h1});
      axi_write(CTRL0_OFFSET, rows[i].c0);
      repeat (20) @(posedge aclk);
      @(negedge aclk);
      chk("channel", rows[i].c0[5:2], actl.channel);
      chk("ext_ref", rows[i].c0[6], actl.ext_ref);
      chk("powered", 1, actl.powered);
      run(rows[i].c0, n);
      chk("conv_time", 1, n >= 11 * rows[i].dv - 4 && n <= 12 * rows[i].dv + 12);
      chk("done_flag", 1, done);
      axi_read(CTRL0_OFFSET, rd);
      chk("start_cleared", rows[i].c0, rd);
      axi_read(RES_HIGH_OFFSET, rd);
      chk("result_high", rows[i].hi, rd);
      axi_read(RES_LOW_OFFSET, rd);
      chk("result_low", rows[i].lo, rd);
    end
    // abort mid-conversion, then a start inside the holdoff
    axi_write(CTRL1_OFFSET, 8'h61);
    axi_write(CTRL0_OFFSET, 8'h81);
    repeat (20) @(posedge aclk);
    axi_write(CTRL0_OFFSET, 8'h83);
    // long enough for the top result bits to be resolved before the abort
    repeat (300) @(posedge aclk);
    axi_read(CTRL0_OFFSET, rd);
    chk("busy", 32'h83, rd);
    axi_write(CTRL0_OFFSET, 8'h81);
    axi_write(CTRL0_OFFSET, 8'h83);
    axi_read(CTRL0_OFFSET, rd);
    chk("holdoff_start", 32'h81, rd);
    repeat (138) @(posedge aclk);
    @(negedge aclk);
    chk("reacquire", 1, actl.sample);
    chk("abort_no_flag", 0, done);
    axi_read(RES_HIGH_OFFSET, rd);
    chk("abort_keep", 32'h0, rd);
    run(8'h81, n);
    axi_write(RES_HIGH_OFFSET, 8'hAA);
    axi_read(RES_HIGH_OFFSET, rd);
    chk("read_only", 32'h03, rd);
    axi_write(CTRL1_OFFSET, 8'h61);
    @(negedge aclk);
    chk("flag_clear", 0, done);
    axi_write(CTRL0_OFFSET, 8'h80);
    @(negedge aclk);
    chk("powered_off", 0, actl.powered);
    axi_write(CTRL0_OFFSET, 8'h82);
    repeat (40) @(posedge aclk);
    axi_read(CTRL0_OFFSET, rd);
    chk("start_when_off", 32'h80, rd);
    // reset in the middle of a conversion
    axi_write(CTRL0_OFFSET, 8'h81);
    repeat (20) @(posedge aclk);
    axi_write(CTRL0_OFFSET, 8'h83);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    read_all_zero();
    close_out();
  end
  // the longest path is about 4000 cycles
  initial begin
    repeat (60000) @(posedge aclk);
    err_total++;
    close_out();
  end
endmodule : testbench
